//--- core/vac_pkg.sv
package vac_pkg;

  localparam logic [5:0] VAC_MAJOR_OPC    = 6'h0a;
  localparam int         VAC_MAJOR_LSB    = 26;
  localparam int         VAC_DST_LSB      = 21;
  localparam int         VAC_SRCA_LSB     = 16;
  localparam int         VAC_SRCB_LSB     = 11;
  localparam int         VAC_RSVD_LSB     = 8;
  localparam int         VAC_MINOR_LSB    = 0;
  localparam int         VAC_GPR_W        = 64;
  localparam int         VAC_BYTE_LANES   = 8;
  localparam int         VAC_HALF_LANES   = 4;
  localparam logic [63:0] VAC_RESULT_RST  = 64'h0000_0000_0000_0000;
  localparam logic [4:0]  VAC_DST_RST     = 5'h00;

  typedef enum logic [7:0] {
    VAC_HALF_ANY_AT_LEAST = 8'h23,
    VAC_BYTE_ANY_ABOVE    = 8'h24,
    VAC_HALF_ANY_ABOVE    = 8'h25,
    VAC_BYTE_ANY_AT_MOST  = 8'h26,
    VAC_HALF_ANY_AT_MOST  = 8'h27,
    VAC_BYTE_ANY_BELOW    = 8'h28,
    VAC_HALF_ANY_BELOW    = 8'h29,
    VAC_BYTE_ANY_DIFFERS  = 8'h2a
  } vac_minor_e;

  typedef enum logic [2:0] {
    VAC_REL_GE = 3'b000,
    VAC_REL_GT = 3'b001,
    VAC_REL_LE = 3'b010,
    VAC_REL_LT = 3'b011,
    VAC_REL_NE = 3'b100
  } vac_rel_e;

  typedef struct packed {
    logic [5:0] major;
    logic [4:0] dst;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [2:0] rsvd;
    logic [7:0] minor;
  } vac_insn_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dst;
    logic [63:0] data;
  } vac_wb_s;

endpackage

//--- core/vac_any_compare.sv
`timescale 1ns/1ps
`default_nettype none

module vac_any_compare
  import vac_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic        ISSUE_VALID_IN,
  input  wire logic [31:0] INSN_IN,
  input  wire logic [63:0] SRC_FIRST_GPR_IN,
  input  wire logic [63:0] SRC_SECOND_GPR_IN,
  output var  logic        ACCEPT_OUT,
  output var  logic        WB_VALID_OUT,
  output var  logic [4:0]  WB_DST_OUT,
  output var  logic [63:0] WB_DATA_OUT
);

  // unsigned lane relation, shared by both lane widths
  function automatic logic lane_rel(input vac_rel_e rel, input logic [15:0] a,
                                    input logic [15:0] b);
    logic r;
    r = 1'b0;
    unique case (rel)
      VAC_REL_GE: r = (a >= b);
      VAC_REL_GT: r = (a > b);
      VAC_REL_LE: r = (a <= b);
      VAC_REL_LT: r = (a < b);
      VAC_REL_NE: r = (a != b);
      default:    r = 1'b0;
    endcase
    return r;
  endfunction

  // byte lane widened to the shared 16-bit compare width
  function automatic logic [15:0] byte_lane(input logic [63:0] word, input int idx);
    logic [7:0] lane;
    lane = word[8*idx +: 8];
    return {8'h00, lane};
  endfunction

  function automatic logic [15:0] half_lane(input logic [63:0] word, input int idx);
    logic [15:0] lane;
    lane = word[16*idx +: 16];
    return lane;
  endfunction

  // any-reduction over the lanes that the current width uses
  function automatic logic any_lane(input logic [7:0] hits, input logic use_half);
    logic r;
    r = 1'b0;
    if (use_half) begin
      r = |hits[VAC_HALF_LANES-1:0];
    end else begin
      r = |hits;
    end
    return r;
  endfunction

  // lane operands, always 16 bits wide
  logic [15:0] a_byte [VAC_BYTE_LANES];
  logic [15:0] b_byte [VAC_BYTE_LANES];
  logic [15:0] a_half [VAC_HALF_LANES];
  logic [15:0] b_half [VAC_HALF_LANES];
  logic [7:0]  byte_hits;
  logic [7:0]  half_hits;
  logic        byte_flag;
  logic        half_flag;
  vac_insn_s  insn;
  logic       hit;
  logic       half;
  vac_rel_e   rel;
  logic       flag;
  vac_wb_s    wb_d;
  vac_wb_s    wb_q;
  logic       acc_d;
  logic       acc_q;

  // reserved field carried in the struct but never looked at
  assign insn = vac_insn_s'(INSN_IN);

  always_comb begin
    hit  = 1'b0;
    half = 1'b0;
    rel  = VAC_REL_GE;
    if (insn.major == VAC_MAJOR_OPC) begin
      hit = 1'b1;
      unique case (insn.minor)
        VAC_HALF_ANY_AT_LEAST: begin
          half = 1'b1;
          rel  = VAC_REL_GE;
        end
        VAC_BYTE_ANY_ABOVE: begin
          half = 1'b0;
          rel  = VAC_REL_GT;
        end
        VAC_HALF_ANY_ABOVE: begin
          half = 1'b1;
          rel  = VAC_REL_GT;
        end
        VAC_BYTE_ANY_AT_MOST: begin
          half = 1'b0;
          rel  = VAC_REL_LE;
        end
        VAC_HALF_ANY_AT_MOST: begin
          half = 1'b1;
          rel  = VAC_REL_LE;
        end
        VAC_BYTE_ANY_BELOW: begin
          half = 1'b0;
          rel  = VAC_REL_LT;
        end
        VAC_HALF_ANY_BELOW: begin
          half = 1'b1;
          rel  = VAC_REL_LT;
        end
        VAC_BYTE_ANY_DIFFERS: begin
          half = 1'b0;
          rel  = VAC_REL_NE;
        end
        // other minor codes belong to other units, not ours
        default:              hit = 1'b0;
      endcase
    end
  end

  // byte lanes 7:0 up to 63:56, half lanes 15:0 up to 63:48
  always_comb begin
    for (int i = 0; i < VAC_BYTE_LANES; i++) begin
      a_byte[i] = byte_lane(SRC_FIRST_GPR_IN, i);
      b_byte[i] = byte_lane(SRC_SECOND_GPR_IN, i);
    end
    for (int i = 0; i < VAC_HALF_LANES; i++) begin
      a_half[i] = half_lane(SRC_FIRST_GPR_IN, i);
      b_half[i] = half_lane(SRC_SECOND_GPR_IN, i);
    end
  end

  // both widths compared in parallel under the decoded relation; the width bit steers the final pick
  always_comb begin
    byte_hits = 8'h00;
    half_hits = 8'h00;
    for (int i = 0; i < VAC_BYTE_LANES; i++) begin
      byte_hits[i] = lane_rel(rel, a_byte[i], b_byte[i]);
    end
    for (int i = 0; i < VAC_HALF_LANES; i++) begin
      half_hits[i] = lane_rel(rel, a_half[i], b_half[i]);
    end
  end

  always_comb begin
    byte_flag = any_lane(byte_hits, 1'b0);
    half_flag = any_lane(half_hits, 1'b1);
    flag      = 1'b0;
    if (half) begin
      flag = half_flag;
    end else begin
      flag = byte_flag;
    end
  end

  // one qualified-issue term feeds both groups so they cannot drift
  logic take;
  assign take = ISSUE_VALID_IN & hit;

  always_comb begin
    acc_d = take;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      acc_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      acc_q <= acc_d;
    end
  end

  // dst and data follow every enabled cycle; qualify them with the strobe
  always_comb begin
    wb_d.valid   = take;
    wb_d.dst     = insn.dst;
    wb_d.data    = {VAC_GPR_W{flag}};
  end

  // reset acts even while the enable is low
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      wb_q.valid <= 1'b0;
      wb_q.dst   <= VAC_DST_RST;
      wb_q.data  <= VAC_RESULT_RST;
    end else if (CLK_EN_IN) begin
      wb_q.valid <= wb_d.valid;
      wb_q.dst   <= wb_d.dst;
      wb_q.data  <= wb_d.data;
    end
  end

  assign ACCEPT_OUT   = acc_q;
  assign WB_VALID_OUT = wb_q.valid;
  assign WB_DST_OUT   = wb_q.dst;
  assign WB_DATA_OUT  = wb_q.data;

endmodule

`default_nettype wire

//--- sim/vac_any_compare_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vac_chk
  import vac_pkg::*;
(
  input wire logic        CLOCK_IN,
  input wire logic        RESET_IN,
  input wire logic        CLK_EN_IN,
  input wire logic        ISSUE_VALID_IN,
  input wire logic [31:0] INSN_IN,
  input wire logic [63:0] SRC_FIRST_GPR_IN,
  input wire logic [63:0] SRC_SECOND_GPR_IN,
  input wire logic        ACCEPT_OUT,
  input wire logic        WB_VALID_OUT,
  input wire logic [4:0]  WB_DST_OUT,
  input wire logic [63:0] WB_DATA_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  wire logic [7:0] mn = INSN_IN[7:0];
  wire logic ok = ISSUE_VALID_IN && INSN_IN[31:26] == VAC_MAJOR_OPC && mn inside {[8'h23:8'h2a]};
  wire logic tk = CLK_EN_IN && ok;
  wire logic eq = SRC_FIRST_GPR_IN == SRC_SECOND_GPR_IN;
  property p_take; tk |=> WB_VALID_OUT; endproperty
  property p_refuse; CLK_EN_IN && !ok |=> !WB_VALID_OUT; endproperty
  property p_ack; ACCEPT_OUT == WB_VALID_OUT; endproperty
  property p_rep; WB_DATA_OUT == '0 || WB_DATA_OUT == '1; endproperty
  property p_ne; tk && mn == 8'h2a |=> WB_DATA_OUT[0] == !$past(eq); endproperty
  property p_eqset; tk && eq && mn inside {8'h23, 8'h26, 8'h27} |=> WB_DATA_OUT[0]; endproperty
  property p_eqclr;
    tk && eq && mn inside {8'h24, 8'h25, 8'h28, 8'h29} |=> !WB_DATA_OUT[0];
  endproperty
  property p_dst; CLK_EN_IN |=> WB_DST_OUT == $past(INSN_IN[25:21]); endproperty
  a_take: assert property (p_take) else $error("no strobe");
  a_refuse: assert property (p_refuse) else $error("bad strobe");
  a_ack: assert property (p_ack) else $error("accept differs");
  a_rep: assert property (p_rep) else $error("mixed bits");
  a_ne: assert property (p_ne) else $error("ne flag");
  a_eqset: assert property (p_eqset) else $error("eq set");
  a_eqclr: assert property (p_eqclr) else $error("eq clr");
  a_dst: assert property (p_dst) else $error("dst");
  c_eq: cover property (tk && eq);
  c_ref: cover property (CLK_EN_IN && ISSUE_VALID_IN && !ok);
  c_hold: cover property (!CLK_EN_IN && WB_VALID_OUT);
endmodule
bind vac_any_compare vac_chk chk_i (.CLOCK_IN, .RESET_IN, .CLK_EN_IN, .ISSUE_VALID_IN,
  .INSN_IN, .SRC_FIRST_GPR_IN, .SRC_SECOND_GPR_IN, .ACCEPT_OUT, .WB_VALID_OUT,
  .WB_DST_OUT, .WB_DATA_OUT);
`default_nettype wire

//--- sim/test_vac_any_compare.sv
`timescale 1ns/1ps
`default_nettype none
module test_vac_any_compare
  import vac_pkg::*;
;
  logic        clk, rst, en, vld, acc, wv, ev;
  logic [31:0] insn, s = 32'h0000_182b;
  logic [63:0] a, b, wdat, edat;
  logic [4:0]  wd, ed;
  int          fails = 0, n_checks = 0;
  vac_any_compare uut (.CLOCK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(en), .ISSUE_VALID_IN(vld),
    .INSN_IN(insn), .SRC_FIRST_GPR_IN(a), .SRC_SECOND_GPR_IN(b), .ACCEPT_OUT(acc),
    .WB_VALID_OUT(wv), .WB_DST_OUT(wd), .WB_DATA_OUT(wdat));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  // odd minor codes are half-word lanes, even ones byte lanes
  function automatic logic fl(logic [7:0] m, logic [63:0] x, logic [63:0] y);
    logic r; logic [15:0] p, q;
    r = 0;
    for (int i = 0; i < (m[0] ? 4 : 8); i++) begin
      p = m[0] ? x[i*16+:16] : 16'(x[i*8+:8]);
      q = m[0] ? y[i*16+:16] : 16'(y[i*8+:8]);
      case (m)
        8'h23: r |= p >= q;
        8'h24, 8'h25: r |= p > q;
        8'h26, 8'h27: r |= p <= q;
        8'h28, 8'h29: r |= p < q;
        default: r |= p != q;
      endcase
    end
    return r;
  endfunction
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000 fails++;
    wrap_up();
  end
  initial begin
    logic [31:0] r; logic [7:0] m;
    rst = 1; en = 1; vld = 0; insn = 0; a = 0; b = 0; ev = 0; ed = 0; edat = 0;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    @(posedge clk);
    #1;
    for (int k = 0; k < 1500; k++) begin
      chk(64'(acc), 64'(ev));
      chk(64'(wv), 64'(ev));
      chk(64'(wd), 64'(ed));
      if (ev) chk(wdat, edat);
      if (ev) chk(wdat, {64{edat[0]}});
      r = rnd(); m = 8'h23 + 8'(r[2:0]);
      if (r[5:3] == 0) m = r[6] ? 8'h2b : 8'h22;
      a = {rnd(), rnd()};
      b = r[9:8] == 0 ? a : {rnd(), rnd()};
      // one flipped bit, at a random position 0 to 63, makes exactly one lane differ
      if (r[11:10] == 0) b = a ^ (64'h0000_0000_0000_0001 << r[17:12]);
      insn = {(r[20] && r[21]) ? 6'h0b : VAC_MAJOR_OPC, r[26:22], 10'h000, r[29:27], m};
      vld = r[31:30] != 0; en = r[19:18] != 0;
      // mid-run reset, then one idle cycle before issuing again
      rst = k == 750;
      if (k == 750 || k == 751) vld = 0;
      if (rst) begin
        ev = 0; ed = 0; edat = 0;
      end else if (en) begin
        ev = vld && insn[31:26] == VAC_MAJOR_OPC && m inside {[8'h23:8'h2a]};
        ed = r[26:22]; edat = {64{fl(m, a, b)}};
      end
      @(posedge clk);
      #1;
    end
    $display("random issue test done");
    wrap_up();
  end
endmodule
`default_nettype wire
